/* File: include/vac_pkg.sv */
// Constants, field layout and carrier types of the video adjust control bank
package vac_pkg;
   // ==========================================================
   // Serial subaddresses
   localparam logic [5:0] ADDR_COPY0 = 6'h19;
   localparam logic [5:0] ADDR_COPY1 = 6'h1A;
   localparam logic [5:0] ADDR_COPY2 = 6'h1B;
   localparam logic [5:0] ADDR_TTX = 6'h1C;
   localparam logic [5:0] ADDR_CONTRAST = 6'h1D;
   localparam logic [5:0] ADDR_U_SCALE = 6'h1E;
   localparam logic [5:0] ADDR_V_SCALE = 6'h1F;
   localparam logic [5:0] ADDR_HUE = 6'h20;
   localparam logic [5:0] ADDR_BRIGHT = 6'h21;
   localparam logic [5:0] ADDR_SHARP = 6'h22;
   // ==========================================================
   // Reset values and write masks
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_SCALE = 8'h80;
   localparam logic [7:0] RST_HUE = 8'h80;
   localparam logic [7:0] RST_BRIGHT = 8'h00;
   localparam logic [7:0] RST_SHARP = 8'h06;
   localparam logic [7:0] MASK_BRIGHT = 8'h7F;
   localparam logic [7:0] MASK_SHARP = 8'h0F;
   // ==========================================================
   // Field positions
   localparam int TTX_FALL_LSB = 0;
   localparam int TTX_RISE_LSB = 4;
   localparam int CW0_TAIL_LSB = 0;
   localparam int CW0_CRC_BIT = 4;
   localparam int CW0_ODD_BIT = 5;
   localparam int CW0_EVEN_BIT = 6;
   localparam int CW0_WSS_BIT = 7;
   localparam int CW1_SHARED_W = 6;
   // ==========================================================
   // Datapath and timing constants
   localparam int PIX_W = 10;
   localparam int SCALE_SHIFT = 7;
   localparam int BRIGHT_SHIFT = 1;
   localparam logic [8:0] HUE_CENTRE = 9'h080;
   localparam logic [2:0] LUMA_FILT_EXT = 3'h4;
   localparam logic [3:0] SHARP_NOMINAL = 4'h6;
   localparam logic [3:0] SHARP_MAX = 4'hC;
   localparam int TTX_DLY_LEN = 31;
   localparam int CGMS_BITS = 20;
   localparam int CGMS_DATA_BITS = 14;
   localparam int WSS_BITS = 14;
   localparam logic [5:0] CRC_POLY = 6'h03;
   localparam logic [5:0] CRC_INIT = 6'h3F;
   // ==========================================================
   // Carrier types
   typedef struct packed {
      logic odd_en;
      logic even_en;
      logic wss_en;
      logic [CGMS_BITS-1:0] cgms_word;
      logic [WSS_BITS-1:0] wss_word;
   } vac_copy_s;
   typedef struct packed {
      logic [PIX_W-1:0] y;
      logic signed [PIX_W-1:0] u;
      logic signed [PIX_W-1:0] v;
   } vac_pix_s;
endpackage : vac_pkg

/* File: sim/tb.sv */
// Self-checking testbench of the video adjust control bank
`timescale 1ns/1ps
`default_nettype none
module tb;
   import vac_pkg::*;
   // ==========================================================
   // Signals
   logic clock, reset, wr_stb, rd_stb, rd_valid, std_ntsc, std_pal, sharpness_filter_en;
   logic active_video, ttx_req_nominal, teletext_request_pulse, pix_valid_in, pix_valid_out;
   logic sharpness_active;
   logic [5:0] sub_addr;
   logic [7:0] wr_data, rd_data, rd_got;
   logic [2:0] luma_filter_select;
   logic [3:0] sharpness_select;
   logic signed [8:0] hue_offset_value;
   vac_pix_s pix_in, pix_out;
   vac_copy_s copy_out;
   logic rd_ok;
   int fail_count = 0;
   int total_checks = 0;
   logic [7:0] rst_tab [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00, 8'h06};
   // ==========================================================
   // Clock and instances
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   vac_host_model host (.clock(clock), .sub_addr(sub_addr), .wr_stb(wr_stb), .wr_data(wr_data),
      .rd_stb(rd_stb), .rd_data(rd_data), .rd_valid(rd_valid));
   vac_video_adjust_bank dut (.clock(clock), .reset(reset), .sub_addr(sub_addr), .wr_stb(wr_stb),
      .wr_data(wr_data), .rd_stb(rd_stb), .rd_data(rd_data), .rd_valid(rd_valid), .std_ntsc(std_ntsc),
      .std_pal(std_pal), .luma_filter_select(luma_filter_select), .sharpness_filter_en(sharpness_filter_en),
      .active_video(active_video), .ttx_req_nominal(ttx_req_nominal),
      .teletext_request_pulse(teletext_request_pulse), .pix_in(pix_in), .pix_valid_in(pix_valid_in),
      .pix_out(pix_out), .pix_valid_out(pix_valid_out), .copy_out(copy_out),
      .hue_offset_value(hue_offset_value), .sharpness_select(sharpness_select),
      .sharpness_active(sharpness_active));
   // ==========================================================
   // Shared tasks
   task automatic check(input logic [39:0] got, input logic [39:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic settle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : settle
   task automatic rd_check(input logic [5:0] addr, input logic [7:0] exp);
      host.read_reg(addr, rd_got, rd_ok);
      check({31'h0, rd_ok, rd_got}, {31'h0, 1'b1, exp});
   endtask : rd_check
   task automatic pix_case(input logic [29:0] pin, input logic [29:0] pexp);
      @(posedge clock);
      #1;
      pix_in = pin;
      pix_valid_in = 1'b1;
      settle(3);
      check({9'h0, pix_valid_out, pix_out}, {9'h0, 1'b1, pexp});
      pix_valid_in = 1'b0;
   endtask : pix_case
   // Nominal request high for 20 clocks; record first high sample and high count
   task automatic ttx_case(input logic [3:0] rise, input logic [3:0] fall, input int efirst, input int ecnt);
      int first;
      int cnt;
      first = 0;
      cnt = 0;
      host.write_reg(ADDR_TTX, {rise, fall});
      settle(4);
      ttx_req_nominal = 1'b1;
      for (int i = 1; i <= 60; i++) begin
         settle(1);
         if (i == 20) ttx_req_nominal = 1'b0;
         if (teletext_request_pulse === 1'b1 && first == 0) first = i;
         if (teletext_request_pulse === 1'b1) cnt++;
      end
      check(first, efirst);
      check(cnt, ecnt);
   endtask : ttx_case
   task automatic final_report();
      $display("checks=%0d mismatches=%0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report
   // ==========================================================
   // Watchdog
   initial begin
      #(25ns * 20000);
      fail_count++;
      final_report();
   end
   // ==========================================================
   // Main sequence
   initial begin
      reset = 1'b1;
      std_ntsc = 1'b1;
      std_pal = 1'b0;
      luma_filter_select = 3'h0;
      sharpness_filter_en = 1'b0;
      active_video = 1'b0;
      ttx_req_nominal = 1'b0;
      pix_in = '0;
      pix_valid_in = 1'b0;
      settle(8);
      reset = 1'b0;
      // Reset values, teletext register at 1C, unmapped place
      for (int a = 0; a < 10; a++) rd_check(6'h19 + a[5:0], rst_tab[a]);
      rd_check(6'h3F, 8'h00);
      host.write_reg(ADDR_BRIGHT, 8'hF1);
      rd_check(ADDR_BRIGHT, 8'h71);
      host.write_reg(ADDR_TTX, 8'h5A);
      rd_check(ADDR_TTX, 8'h5A);
      // Scaling and brightness
      host.write_reg(ADDR_CONTRAST, 8'h97);
      host.write_reg(ADDR_U_SCALE, 8'h40);
      host.write_reg(ADDR_V_SCALE, 8'hFF);
      host.write_reg(ADDR_BRIGHT, 8'h0F);
      pix_case({10'h100, 10'h39C, 10'h0C8}, {10'h14C, 10'h3CE, 10'h18E});
      host.write_reg(ADDR_CONTRAST, 8'h80);
      host.write_reg(ADDR_BRIGHT, 8'h71);
      pix_case({10'h100, 10'h39C, 10'h0C8}, {10'h0E2, 10'h3CE, 10'h18E});
      host.write_reg(ADDR_CONTRAST, 8'hFF);
      host.write_reg(ADDR_BRIGHT, 8'h00);
      pix_case({10'h3FF, 10'h000, 10'h000}, {10'h3FF, 10'h000, 10'h000});
      // Hue offset only during active video
      host.write_reg(ADDR_HUE, 8'h97);
      active_video = 1'b1;
      settle(2);
      check({31'h0, hue_offset_value}, 40'h017);
      host.write_reg(ADDR_HUE, 8'h69);
      settle(2);
      check({31'h0, hue_offset_value}, 40'h1E9);
      active_video = 1'b0;
      settle(2);
      check({31'h0, hue_offset_value}, 40'h000);
      // Sharpness selection and its enable conditions
      luma_filter_select = LUMA_FILT_EXT;
      sharpness_filter_en = 1'b1;
      host.write_reg(ADDR_SHARP, 8'h0C);
      settle(2);
      check({sharpness_active, sharpness_select}, 40'h1C);
      host.write_reg(ADDR_SHARP, 8'h0F);
      settle(2);
      check({sharpness_active, sharpness_select}, 40'h1C);
      host.write_reg(ADDR_SHARP, 8'h00);
      settle(2);
      check({sharpness_active, sharpness_select}, 40'h10);
      luma_filter_select = 3'h3;
      settle(2);
      check({sharpness_active, sharpness_select}, 40'h06);
      luma_filter_select = LUMA_FILT_EXT;
      sharpness_filter_en = 1'b0;
      settle(2);
      check({sharpness_active, sharpness_select}, 40'h06);
      // Copy and widescreen words by standard
      host.write_reg(ADDR_COPY1, 8'hC5);
      host.write_reg(ADDR_COPY2, 8'h3A);
      host.write_reg(ADDR_COPY0, 8'h6B);
      settle(2);
      check(copy_out, {3'b110, 20'hB3AC5, 14'h0});
      host.write_reg(ADDR_COPY0, 8'hEB);
      std_ntsc = 1'b0;
      std_pal = 1'b1;
      settle(2);
      check(copy_out, {3'b001, 20'h0, 8'h3A, 6'h05});
      std_ntsc = 1'b1;
      std_pal = 1'b0;
      host.write_reg(ADDR_COPY0, 8'h3B);
      settle(2);
      check(copy_out, {3'b100, 6'h16, 14'h3AC5, 14'h0});
      // Teletext request edges
      ttx_case(4'h0, 4'h0, 2, 20);
      ttx_case(4'h5, 4'h0, 7, 20);
      ttx_case(4'h2, 4'hF, 4, 35);
      final_report();
   end
endmodule : tb
`default_nettype wire

/* File: sim/vac_host_model.sv */
// Host side model: register access through the decoded subaddress port
`timescale 1ns/1ps
`default_nettype none
module vac_host_model (
   input wire logic clock,
   output logic [5:0] sub_addr,
   output logic wr_stb,
   output logic [7:0] wr_data,
   output logic rd_stb,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid
);
   import vac_pkg::*;
   // ==========================================================
   // Idle levels at time zero
   initial begin
      sub_addr = 6'h00;
      wr_stb = 1'b0;
      wr_data = 8'h00;
      rd_stb = 1'b0;
   end
   // One write strobe; reserved sharpness bits always sent as zero
   task automatic write_reg(input logic [5:0] addr, input logic [7:0] data);
      @(posedge clock);
      #1;
      sub_addr = addr;
      wr_data = (addr == ADDR_SHARP) ? (data & MASK_SHARP) : data;
      wr_stb = 1'b1;
      @(posedge clock);
      #1;
      wr_stb = 1'b0;
      wr_data = ~wr_data; // Released data no longer shows the last value
   endtask : write_reg
   // One read strobe; answer taken just after the strobe edge, while it stands
   task automatic read_reg(input logic [5:0] addr, output logic [7:0] data, output logic valid);
      @(posedge clock);
      #1;
      sub_addr = addr;
      rd_stb = 1'b1;
      @(posedge clock);
      #1;
      rd_stb = 1'b0;
      data = rd_data;
      valid = rd_valid;
   endtask : read_reg
endmodule : vac_host_model
`default_nettype wire

/* File: src/vac_scaler.sv */
// One component scaler: data times coefficient over 128, registered
`timescale 1ns/1ps
`default_nettype none
module vac_scaler #(
   parameter int IN_W = 10,
   parameter bit SIGNED_IN = 1'b0
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [IN_W-1:0] din,
   input wire logic [7:0] coef,
   output logic signed [IN_W+1:0] dout
);
   import vac_pkg::*;
   logic signed [IN_W:0] din_x;
   logic signed [8:0] coef_x;
   logic signed [IN_W+9:0] prod;
   // Sign or zero extension, then full product
   assign din_x = SIGNED_IN ? $signed({din[IN_W-1], din}) : $signed({1'b0, din});
   assign coef_x = $signed({1'b0, coef});
   assign prod = din_x * coef_x;
   // Divide by 128 by dropping the low bits
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         dout <= '0;
      end else begin
         dout <= prod[SCALE_SHIFT +: IN_W+2];
      end
   end
endmodule : vac_scaler
`default_nettype wire

/* File: src/vac_ttx_pulse.sv */
// Teletext request pulse edge placement from a nominal request
`timescale 1ns/1ps
`default_nettype none
module vac_ttx_pulse (
   input wire logic clock,
   input wire logic reset,
   input wire logic ttx_req_nominal,
   input wire logic [3:0] ttx_rise_edge_pos,
   input wire logic [3:0] ttx_fall_edge_pos,
   output logic teletext_request_pulse
);
   import vac_pkg::*;
   logic [TTX_DLY_LEN-1:0] dly_q;
   logic [4:0] start_tap;
   logic [4:0] end_tap;
   // Delay line of the nominal request
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         dly_q <= '0;
      end else begin
         dly_q <= {dly_q[TTX_DLY_LEN-2:0], ttx_req_nominal};
      end
   end
   // End tap rides on the start tap, so a zero fall field keeps the length
   assign start_tap = {1'b0, ttx_rise_edge_pos};
   assign end_tap = start_tap + {1'b0, ttx_fall_edge_pos};
   // Union of both copies spans start+rise to end+rise+fall
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         teletext_request_pulse <= 1'b0;
      end else begin
         teletext_request_pulse <= dly_q[start_tap] | dly_q[end_tap];
      end
   end
   // ==========================================================
   // Checks
   zero_edge_delay_a: assert property (@(posedge clock) disable iff (reset)
      (ttx_rise_edge_pos == 4'h0 && ttx_fall_edge_pos == 4'h0)[*3] |->
      teletext_request_pulse == $past(ttx_req_nominal, 2))
      else $error("ttx pulse not aligned at zero edge settings");
   rise_shift_a: assert property (@(posedge clock) disable iff (reset)
      ($rose(ttx_req_nominal) && ttx_rise_edge_pos == 4'h5 && ttx_fall_edge_pos == 4'h0) ##1
      (ttx_rise_edge_pos == 4'h5 && ttx_fall_edge_pos == 4'h0)[*6] |=> $rose(teletext_request_pulse))
      else $error("ttx pulse start not shifted by rise field");
endmodule : vac_ttx_pulse
`default_nettype wire

/* File: src/vac_video_adjust_bank.sv */
// Video adjust control bank: registers, copy signalling, scaling, hue, brightness
// Function
// - Fall field moves the request pulse end by 0 to 15 clocks.
// - Zero fall field keeps pulse length constant when rise field changes.
// - Rise field shifts request pulse start by 0 to 15 pixel clocks.
// - Low four bits of copy register 0 are the final copy bits only.
// - CRC bit set computes the six-bit CRC; clear sends stored bits.
// - Odd-field copy enable acts only in NTSC.
// - Even-field copy enable acts only in NTSC.
// - Widescreen enable acts only in PAL.
// - Shared fields of copy registers 1 and 2 are copy or widescreen by standard.
// - Top two bits of copy register 1 are always copy payload.
// - Luma is multiplied by contrast over 128, range 0.0 to 2.0.
// - U is multiplied by its scale over 128, range 0.0 to 2.0.
// - V is multiplied by its scale over 128, range 0.0 to 2.0.
// - Active video hue offset is register minus 128 phase steps.
// - Signed seven-bit brightness is added onto the scaled luma.
// - Brightness range +15 to -7.5 IRE, or 22.5 to 0 with pedestal.
// - Four-bit sharpness code picks one of thirteen responses, 6 nominal.
// - Sharpness acts only in extended luma filter mode with its enable.
// - Teletext edge register sits at subaddress 1C.
`timescale 1ns/1ps
`default_nettype none
module vac_video_adjust_bank (
   input wire logic clock,
   input wire logic reset,
   input wire logic [5:0] sub_addr,
   input wire logic wr_stb,
   input wire logic [7:0] wr_data,
   input wire logic rd_stb,
   output logic [7:0] rd_data,
   output logic rd_valid,
   input wire logic std_ntsc,
   input wire logic std_pal,
   input wire logic [2:0] luma_filter_select,
   input wire logic sharpness_filter_en,
   input wire logic active_video,
   input wire logic ttx_req_nominal,
   output logic teletext_request_pulse,
   input wire vac_pkg::vac_pix_s pix_in,
   input wire logic pix_valid_in,
   output vac_pkg::vac_pix_s pix_out,
   output logic pix_valid_out,
   output vac_pkg::vac_copy_s copy_out,
   output logic signed [8:0] hue_offset_value,
   output logic [3:0] sharpness_select,
   output logic sharpness_active
);
   import vac_pkg::*;

   // ==========================================================
   // Register storage
   logic [7:0] ttx_q;
   logic [7:0] cw0_q;
   logic [7:0] cw1_q;
   logic [7:0] cw2_q;
   logic [7:0] contrast_q;
   logic [7:0] u_scale_q;
   logic [7:0] v_scale_q;
   logic [7:0] hue_q;
   logic [7:0] bright_q;
   logic [7:0] sharp_q;
   logic [7:0] rd_d;

   // CRC-6 over the first fourteen copy bits, bit 0 sent first
   function automatic logic [5:0] vac_crc6(input logic [CGMS_DATA_BITS-1:0] d);
      logic [5:0] c;
      logic fb;
      c = CRC_INIT;
      fb = 1'b0;
      for (int i = 0; i < CGMS_DATA_BITS; i++) begin
         fb = d[i] ^ c[5];
         c = {c[4:0], 1'b0} ^ (fb ? CRC_POLY : 6'h00);
      end
      return c;
   endfunction : vac_crc6

   // Subaddress decoded writes; unmapped subaddresses are ignored
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ttx_q <= RST_ZERO;
         cw0_q <= RST_ZERO;
         cw1_q <= RST_ZERO;
         cw2_q <= RST_ZERO;
         contrast_q <= RST_SCALE;
         u_scale_q <= RST_SCALE;
         v_scale_q <= RST_SCALE;
         hue_q <= RST_HUE;
         bright_q <= RST_BRIGHT;
         sharp_q <= RST_SHARP;
      end else if (wr_stb) begin
         unique case (sub_addr)
            ADDR_TTX: ttx_q <= wr_data;
            ADDR_COPY0: cw0_q <= wr_data;
            ADDR_COPY1: cw1_q <= wr_data;
            ADDR_COPY2: cw2_q <= wr_data;
            ADDR_CONTRAST: contrast_q <= wr_data;
            ADDR_U_SCALE: u_scale_q <= wr_data;
            ADDR_V_SCALE: v_scale_q <= wr_data;
            ADDR_HUE: hue_q <= wr_data;
            ADDR_BRIGHT: bright_q <= wr_data & MASK_BRIGHT;
            ADDR_SHARP: sharp_q <= wr_data & MASK_SHARP;
            default: ;
         endcase
      end
   end

   // Read mux; reserved bits read zero, unmapped reads zero
   always_comb begin
      rd_d = 8'h00;
      unique case (sub_addr)
         ADDR_TTX: rd_d = ttx_q;
         ADDR_COPY0: rd_d = cw0_q;
         ADDR_COPY1: rd_d = cw1_q;
         ADDR_COPY2: rd_d = cw2_q;
         ADDR_CONTRAST: rd_d = contrast_q;
         ADDR_U_SCALE: rd_d = u_scale_q;
         ADDR_V_SCALE: rd_d = v_scale_q;
         ADDR_HUE: rd_d = hue_q;
         ADDR_BRIGHT: rd_d = bright_q;
         ADDR_SHARP: rd_d = sharp_q;
         default: rd_d = 8'h00;
      endcase
   end

   // Read answer one clock after the strobe
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= rd_stb;
         if (rd_stb) begin
            rd_data <= rd_d;
         end
      end
   end

   // ==========================================================
   // Teletext request pulse
   vac_ttx_pulse u_ttx (
      .clock(clock),
      .reset(reset),
      .ttx_req_nominal(ttx_req_nominal),
      .ttx_rise_edge_pos(ttx_q[TTX_RISE_LSB +: 4]),
      .ttx_fall_edge_pos(ttx_q[TTX_FALL_LSB +: 4]),
      .teletext_request_pulse(teletext_request_pulse)
   );

   // ==========================================================
   // Copy generation and widescreen signalling
   logic [CGMS_BITS-1:0] copy_raw;
   logic [CGMS_BITS-1:0] copy_word;
   logic copy_crc_auto;
   // Transmit order: shared low, copy-only pair, register 2, then tail bits
   assign copy_raw = {cw0_q[CW0_TAIL_LSB +: 4], cw2_q, cw1_q};
   assign copy_crc_auto = cw0_q[CW0_CRC_BIT];
   always_comb begin
      copy_word = copy_raw;
      if (copy_crc_auto) begin
         copy_word[CGMS_BITS-1:CGMS_DATA_BITS] = vac_crc6(copy_raw[CGMS_DATA_BITS-1:0]);
      end
   end

   // Enables gated by standard; widescreen word only carries data in PAL
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         copy_out <= '0;
      end else begin
         copy_out.odd_en <= cw0_q[CW0_ODD_BIT] & std_ntsc;
         copy_out.even_en <= cw0_q[CW0_EVEN_BIT] & std_ntsc;
         copy_out.wss_en <= cw0_q[CW0_WSS_BIT] & std_pal;
         copy_out.cgms_word <= std_ntsc ? copy_word : '0;
         copy_out.wss_word <= std_pal ? {cw2_q, cw1_q[CW1_SHARED_W-1:0]} : '0;
      end
   end

   // ==========================================================
   // Contrast and colour scaling
   logic signed [PIX_W+1:0] y_scaled;
   logic signed [PIX_W+1:0] u_scaled;
   logic signed [PIX_W+1:0] v_scaled;
   logic signed [PIX_W+2:0] y_bright;
   logic [1:0] valid_q;

   vac_scaler #(.IN_W(PIX_W), .SIGNED_IN(1'b0)) u_scale_y (
      .clock(clock),
      .reset(reset),
      .din(pix_in.y),
      .coef(contrast_q),
      .dout(y_scaled)
   );
   vac_scaler #(.IN_W(PIX_W), .SIGNED_IN(1'b1)) u_scale_u (
      .clock(clock),
      .reset(reset),
      .din(pix_in.u),
      .coef(u_scale_q),
      .dout(u_scaled)
   );
   vac_scaler #(.IN_W(PIX_W), .SIGNED_IN(1'b1)) u_scale_v (
      .clock(clock),
      .reset(reset),
      .din(pix_in.v),
      .coef(v_scale_q),
      .dout(v_scaled)
   );

   // Signed brightness setup added after scaling
   assign y_bright = $signed({y_scaled[PIX_W+1], y_scaled}) +
      ($signed({{(PIX_W-4){bright_q[6]}}, bright_q[6:0]}) <<< BRIGHT_SHIFT);

   // Saturate and register the adjusted pixel
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pix_out <= '0;
      end else begin
         if (y_bright < 0) begin
            pix_out.y <= '0;
         end else if (y_bright > $signed({3'b000, {PIX_W{1'b1}}})) begin
            pix_out.y <= {PIX_W{1'b1}};
         end else begin
            pix_out.y <= y_bright[PIX_W-1:0];
         end
         if (u_scaled > $signed({3'b000, {(PIX_W-1){1'b1}}})) begin
            pix_out.u <= {1'b0, {(PIX_W-1){1'b1}}};
         end else if (u_scaled < -$signed({3'b001, {(PIX_W-1){1'b0}}})) begin
            pix_out.u <= {1'b1, {(PIX_W-1){1'b0}}};
         end else begin
            pix_out.u <= u_scaled[PIX_W-1:0];
         end
         if (v_scaled > $signed({3'b000, {(PIX_W-1){1'b1}}})) begin
            pix_out.v <= {1'b0, {(PIX_W-1){1'b1}}};
         end else if (v_scaled < -$signed({3'b001, {(PIX_W-1){1'b0}}})) begin
            pix_out.v <= {1'b1, {(PIX_W-1){1'b0}}};
         end else begin
            pix_out.v <= v_scaled[PIX_W-1:0];
         end
      end
   end

   // Valid follows the two pixel stages
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         valid_q <= 2'b00;
      end else begin
         valid_q <= {valid_q[0], pix_valid_in};
      end
   end
   assign pix_valid_out = valid_q[1];

   // ==========================================================
   // Hue offset during active video only
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         hue_offset_value <= '0;
      end else if (active_video) begin
         hue_offset_value <= $signed({1'b0, hue_q} - HUE_CENTRE);
      end else begin
         hue_offset_value <= '0;
      end
   end

   // ==========================================================
   // Sharpness selection, nominal unless extended filter mode and enabled
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sharpness_select <= SHARP_NOMINAL;
         sharpness_active <= 1'b0;
      end else if (luma_filter_select == LUMA_FILT_EXT && sharpness_filter_en) begin
         sharpness_active <= 1'b1;
         sharpness_select <= (sharp_q[3:0] > SHARP_MAX) ? SHARP_MAX : sharp_q[3:0];
      end else begin
         sharpness_active <= 1'b0;
         sharpness_select <= SHARP_NOMINAL;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   hue_active_offset_a: assert property (active_video |=>
      hue_offset_value == $signed({1'b0, $past(hue_q)} - HUE_CENTRE))
      else $error("hue offset not register minus 128");
   hue_blank_zero_a: assert property (!active_video |=> hue_offset_value == 9'sh000)
      else $error("hue offset outside active video");
   odd_ntsc_gate_a: assert property (##1 copy_out.odd_en == $past(cw0_q[CW0_ODD_BIT] && std_ntsc))
      else $error("odd field enable not gated by NTSC");
   even_ntsc_gate_a: assert property (##1 copy_out.even_en == $past(cw0_q[CW0_EVEN_BIT] && std_ntsc))
      else $error("even field enable outside NTSC");
   wss_pal_gate_a: assert property (##1 copy_out.wss_en == $past(cw0_q[CW0_WSS_BIT] && std_pal))
      else $error("widescreen enable not gated by PAL");
   crc_auto_value_a: assert property ((copy_crc_auto && std_ntsc) |=>
      copy_out.cgms_word[CGMS_BITS-1:CGMS_DATA_BITS] == vac_crc6($past(copy_raw[CGMS_DATA_BITS-1:0])))
      else $error("internal copy CRC wrong");
   sharp_mode_gate_a: assert property (sharpness_active |->
      $past(luma_filter_select) == LUMA_FILT_EXT && $past(sharpness_filter_en) && sharpness_select <= SHARP_MAX)
      else $error("sharpness active outside extended mode");
   sharp_reserved_zero_a: assert property ((rd_stb && sub_addr == ADDR_SHARP) |=> rd_data[7:4] == 4'h0)
      else $error("sharpness reserved bits read nonzero");
   sharp_nominal_a: assert property (!(luma_filter_select == LUMA_FILT_EXT && sharpness_filter_en) |=>
      sharpness_select == SHARP_NOMINAL && !sharpness_active)
      else $error("sharpness not nominal outside extended mode");
   read_answer_a: assert property (rd_stb |=> rd_valid && rd_data == $past(rd_d))
      else $error("read answer not one cycle after strobe");
   unity_luma_a: assert property ((contrast_q == RST_SCALE && bright_q == RST_ZERO && pix_in.y < 10'h3F0)[*1]
      ##1 (contrast_q == RST_SCALE && bright_q == RST_ZERO) |=> pix_out.y == $past(pix_in.y, 2))
      else $error("unity contrast changes luma");

   wss_seen_c: cover property (copy_out.wss_en);
   crc_seen_c: cover property (copy_crc_auto && copy_out.odd_en);
   sharp_seen_c: cover property (sharpness_active && sharpness_select == SHARP_MAX);
   ttx_seen_c: cover property ($rose(teletext_request_pulse));
endmodule : vac_video_adjust_bank
`default_nettype wire
